// File: design/sdoi_top.sv
// Axis 1 output process image with AHB-Lite register access.
// Assumes a single AHB-Lite master, word transfers, and error detectors on ref_clk.
`timescale 1ns/1ns

// Contract
// RQ1: Output image holds at most 32 bytes of control data.
// RQ2: Bit 0.0 enables torque switch-off path A of axis 1.
// RQ3: Bit 0.1 acknowledges a switch-off path error of axis 1.
// RQ4: Bit 0.2 tells the drive its axis 1 output stage is enabled.
// RQ5: Bit 2.0 acknowledges an encoder supply voltage error of axis 1.
// RQ6: Bit 4.0 is passed to the drive as axis 1 group error status.
// RQ7: Falling edge on bit 8.0 to 9.7 logs code 0xD300 plus bit number.
// RQ8: Bit 18.0 activates the axis 1 primary feedback module.
// RQ9: Bit 18.1 acknowledges a primary feedback module error of axis 1.
// RQ10: Bit 18.2 sets the reference position of the primary feedback module.
// RQ11: Reserved drive command bits of byte 6 have no effect.
module sdoi_top #(
  parameter int CYCLE_CLKS = sdoi_pkg::LOGIC_CYCLE_CLKS,
  parameter int HIST_DEPTH = sdoi_pkg::HIST_DEPTH_DEF
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Error detectors of axis 1
  input wire logic [sdoi_pkg::ERR_N-1:0] err_detect,
  // Drive side
  output sdoi_pkg::sdoi_drive_t drive,
  output logic [sdoi_pkg::ERR_N-1:0] err_active
);
  import sdoi_pkg::*;

  localparam int PW = $clog2(HIST_DEPTH);

  if (CYCLE_CLKS < 2 || CYCLE_CLKS > 65535 || HIST_DEPTH < 2 || HIST_DEPTH > 128
      || (1 << PW) != HIST_DEPTH)
  begin : g_bad_param
    $error("sdoi_top: unsupported CYCLE_CLKS or HIST_DEPTH");
  end

  sdoi_state_t s_q;
  sdoi_state_t s_d;
  logic [DIAG_BITS-1:0] falls;
  logic [3:0] pick;
  logic mem_we;
  logic [15:0] mem_code;
  logic [15:0] mem_rdata;
  logic ap;
  logic [7:0] ap_ofs;
  logic ap_map;

  // Index of the lowest set bit
  function automatic logic [3:0] lowest(input logic [DIAG_BITS-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = DIAG_BITS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = 4'(i);
      end
    end
    return r;
  endfunction : lowest

  // Register read decode
  function automatic logic [31:0] rd_word(input sdoi_state_t st, input logic [7:0] ofs,
                                          input logic [ERR_N-1:0] errs, input logic [15:0] hd);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (ofs < 8'(IMG_BYTES))
    begin
      r = st.shadow[ofs[4:2]] & IMG_WMASK[ofs[4:2]];
    end
    else if (ofs == OFS_STATUS)
    begin
      r[ERR_N-1:0] = errs;
      r[8] = st.active[W_CTRL][BIT_PATH_A];
      r[9] = st.active[W_CTRL][BIT_STAGE];
      r[10] = st.active[W_DRIVE][BIT_GROUP];
      r[11] = st.active[W_FB][BIT_FB_ACT];
      r[23:16] = st.count;
    end
    else if (ofs == OFS_HIST_IDX)
    begin
      r[7:0] = st.hist_idx;
    end
    else if (ofs == OFS_HIST_DATA)
    begin
      r[15:0] = hd;
    end
    return r;
  endfunction : rd_word

  always_comb
  begin
    s_d = s_q;
    ap = hsel && htrans[1] && hready;
    ap_ofs = haddr[7:0];
    ap_map = (haddr[31:8] == 24'h00_0000) && (haddr[1:0] == 2'b00);
    // Bus write data phase; only the image words and the index take data
    s_d.dph_we = ap && hwrite && ap_map;
    s_d.dph_idx = ap_ofs[7:2];
    if (s_q.dph_we)
    begin
      if (s_q.dph_idx < 6'(IMG_WORDS)) // [RQ1]
      begin
        // Reserved bits, byte 6 included, never store
        s_d.shadow[s_q.dph_idx[2:0]] = (s_q.shadow[s_q.dph_idx[2:0]] & ~IMG_WMASK[s_q.dph_idx[2:0]])
                                       | (hwdata & IMG_WMASK[s_q.dph_idx[2:0]]); // [RQ11]
      end
      else if (s_q.dph_idx == OFS_HIST_IDX[7:2])
      begin
        s_d.hist_idx = hwdata[7:0];
      end
    end
    // Logic cycle: the written image becomes the acting image
    s_d.tick = (s_q.cyc_cnt == 16'(CYCLE_CLKS - 1));
    s_d.cyc_cnt = s_d.tick ? 16'h0000 : s_q.cyc_cnt + 16'h0001;
    s_d.ack_pulse = '0;
    s_d.ref_pulse = 1'b0;
    falls = '0;
    if (s_q.tick)
    begin
      s_d.active = s_q.shadow; // [RQ2] [RQ4] [RQ6] [RQ8]
      falls = s_q.active[W_DIAG][DIAG_BITS-1:0] & ~s_q.shadow[W_DIAG][DIAG_BITS-1:0]; // [RQ7]
      s_d.ack_pulse[ERR_SWOFF] = s_q.shadow[W_CTRL][BIT_SWOFF_ACK] & ~s_q.active[W_CTRL][BIT_SWOFF_ACK]; // [RQ3]
      s_d.ack_pulse[ERR_ENC] = s_q.shadow[W_CTRL][BIT_ENC_ACK] & ~s_q.active[W_CTRL][BIT_ENC_ACK]; // [RQ5]
      s_d.ack_pulse[ERR_FB] = s_q.shadow[W_FB][BIT_FB_ACK] & ~s_q.active[W_FB][BIT_FB_ACK]; // [RQ9]
      s_d.ref_pulse = s_q.shadow[W_FB][BIT_FB_REF] & ~s_q.active[W_FB][BIT_FB_REF]; // [RQ10]
    end
    // One history entry per clock, lowest message bit first
    pick = lowest(s_q.pend);
    mem_we = |s_q.pend;
    mem_code = DIAG_CODE_BASE + 16'(pick); // [RQ7]
    s_d.pend = s_q.pend;
    if (mem_we)
    begin
      s_d.pend[pick] = 1'b0;
      s_d.wr_ptr = 8'(s_q.wr_ptr + 8'h01) & 8'(HIST_DEPTH - 1);
      if (s_q.count != 8'(HIST_DEPTH))
      begin
        s_d.count = s_q.count + 8'h01;
      end
    end
    s_d.pend = s_d.pend | falls;
    // Reads see a write made in the data phase just before
    if (ap && !hwrite)
    begin
      s_d.hrdata = ap_map ? rd_word(s_d, ap_ofs, err_active, mem_rdata) : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  for (genvar g = 0; g < ERR_N; g++)
  begin : g_err
    sdoi_err_flag u_flag (
      .ref_clk(ref_clk),
      .rst(rst),
      .detect(err_detect[g]),
      .ack(s_q.ack_pulse[g]),
      .flag_q(err_active[g])
    );
  end

  sdoi_hist_mem #(
    .WIDTH(16),
    .DEPTH(HIST_DEPTH)
  ) u_hist (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(mem_we),
    .wr_addr(s_q.wr_ptr[PW-1:0]),
    .wr_data(mem_code),
    .rd_addr(s_q.hist_idx[PW-1:0]),
    .rd_data(mem_rdata)
  );

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_q.hrdata;
  assign drive.path_a_enable = s_q.active[W_CTRL][BIT_PATH_A]; // [RQ2]
  assign drive.output_stage_enable = s_q.active[W_CTRL][BIT_STAGE]; // [RQ4]
  assign drive.group_error_status = s_q.active[W_DRIVE][BIT_GROUP]; // [RQ6]
  assign drive.feedback_activate = s_q.active[W_FB][BIT_FB_ACT]; // [RQ8]
  assign drive.feedback_set_reference = s_q.ref_pulse; // [RQ10]

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  sequence diag0_fall;
    s_q.tick && s_q.active[W_DIAG][0] && !s_q.shadow[W_DIAG][0];
  endsequence
  sequence diag0_logged;
    mem_we && (mem_code == 16'hD300);
  endsequence

  path_a_follow_a: assert property (s_q.tick |=> drive.path_a_enable == $past(s_q.shadow[W_CTRL][0])) // [RQ2]
    else $error("path A enable does not follow image bit");
  stage_follow_a: assert property (s_q.tick |=> drive.output_stage_enable == $past(s_q.shadow[W_CTRL][2])) // [RQ4]
    else $error("output stage enable does not follow image bit");
  group_follow_a: assert property (s_q.tick |=> drive.group_error_status == $past(s_q.shadow[W_DRIVE][0])) // [RQ6]
    else $error("group error status does not follow image bit");
  feedback_follow_a: assert property (s_q.tick |=> drive.feedback_activate == $past(s_q.shadow[W_FB][16])) // [RQ8]
    else $error("feedback activate does not follow image bit");
  image_bound_a: assert property (s_q.dph_we && s_q.dph_idx >= 6'd8 |=> $stable(s_q.shadow)) // [RQ1]
    else $error("write outside image changed the image");
  reserved_quiet_a: assert property (s_q.shadow[W_DRIVE][RSV_MSB:RSV_LSB] == 8'h00) // [RQ11]
    else $error("reserved command bits were stored");
  diag_code_a: assert property (mem_we |-> mem_code[15:4] == 12'hD30 && s_q.pend[mem_code[3:0]]) // [RQ7]
    else $error("history code out of range");
  diag_logged_a: assert property (diag0_fall |-> ##1 diag0_logged) // [RQ7]
    else $error("falling message bit not logged");
  setref_pulse_a: assert property (drive.feedback_set_reference |-> $past(s_q.tick) ##1 !drive.feedback_set_reference) // [RQ10]
    else $error("set reference pulse malformed");
endmodule : sdoi_top

// File: inc/sdoi_pkg.sv
// Constants and carrier types of the axis 1 output process image.
// Assumes one clock domain and a word-wide AHB-Lite register view.
package sdoi_pkg;

  // Image size and word layout
  localparam int IMG_BYTES = 32;
  localparam int IMG_WORDS = IMG_BYTES / 4;
  localparam int W_CTRL = 0;
  localparam int W_DRIVE = 1;
  localparam int W_DIAG = 2;
  localparam int W_FB = 4;

  // Bit positions inside their words
  localparam int BIT_PATH_A = 0;
  localparam int BIT_SWOFF_ACK = 1;
  localparam int BIT_STAGE = 2;
  localparam int BIT_ENC_ACK = 16;
  localparam int BIT_GROUP = 0;
  localparam int RSV_LSB = 16;
  localparam int RSV_MSB = 23;
  localparam int BIT_FB_ACT = 16;
  localparam int BIT_FB_ACK = 17;
  localparam int BIT_FB_REF = 18;

  // Writable bits per image word; reserved bits read as zero
  localparam logic [31:0] IMG_WMASK [IMG_WORDS] = '{
    32'h0001_0007, 32'h0000_0001, 32'h0000_FFFF, 32'h0000_0000,
    32'h0007_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  // Extra register byte offsets
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_HIST_IDX = 8'h24;
  localparam logic [7:0] OFS_HIST_DATA = 8'h28;

  // Diagnostic message codes
  localparam int DIAG_BITS = 16;
  localparam logic [15:0] DIAG_CODE_BASE = 16'hD300;

  // Error flag indexes
  localparam int ERR_SWOFF = 0;
  localparam int ERR_ENC = 1;
  localparam int ERR_FB = 2;
  localparam int ERR_N = 3;

  // Defaults and reset values
  localparam int LOGIC_CYCLE_CLKS = 100;
  localparam int HIST_DEPTH_DEF = 16;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  typedef struct packed {
    logic path_a_enable;
    logic output_stage_enable;
    logic group_error_status;
    logic feedback_activate;
    logic feedback_set_reference;
  } sdoi_drive_t;

  typedef struct packed {
    logic [IMG_WORDS-1:0][31:0] shadow;
    logic [IMG_WORDS-1:0][31:0] active;
    logic [DIAG_BITS-1:0] pend;
    logic [ERR_N-1:0] ack_pulse;
    logic ref_pulse;
    logic tick;
    logic [15:0] cyc_cnt;
    logic [7:0] wr_ptr;
    logic [7:0] count;
    logic [7:0] hist_idx;
    logic dph_we;
    logic [5:0] dph_idx;
    logic [31:0] hrdata;
  } sdoi_state_t;

endpackage : sdoi_pkg

// File: design/sdoi_hist_mem.sv
// Diagnostic history memory, one code per word.
// Assumes the writer and reader share ref_clk; read data is registered.
`timescale 1ns/1ns
module sdoi_hist_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) < DEPTH)
  begin : g_bad_param
    $error("sdoi_hist_mem: unsupported WIDTH or DEPTH");
  end

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rd_data <= '0;
    end
    else
    begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule : sdoi_hist_mem

// File: design/sdoi_err_flag.sv
// Sticky error flag cleared by an acknowledge pulse.
// Assumes detect and ack are synchronous to ref_clk.
`timescale 1ns/1ns
module sdoi_err_flag (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Event and clear
  input wire logic detect,
  input wire logic ack,
  // Flag
  output logic flag_q
);
  logic flag_d;

  // A new detection beats a clear in the same cycle
  always_comb
  begin
    flag_d = detect | (flag_q & ~ack); // [RQ3] [RQ5] [RQ9]
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flag_q <= 1'b0;
    end
    else
    begin
      flag_q <= flag_d;
    end
  end

  ack_clears_a: assert property (@(posedge ref_clk) disable iff (rst) // [RQ3] [RQ5] [RQ9]
    ack && !detect |=> !flag_q)
    else $error("error flag not cleared by acknowledge");
  set_wins_a: assert property (@(posedge ref_clk) disable iff (rst)
    detect |=> flag_q)
    else $error("error flag lost a detection");
endmodule : sdoi_err_flag

// File: verification/sdoi_drive_model.sv
// Drive and error detector model facing the axis 1 output image.
// Assumes raise is called right after a rising edge of ref_clk.
`timescale 1ns/1ns
module sdoi_drive_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Drive commands
  input wire sdoi_pkg::sdoi_drive_t drive,
  // Detector levels
  output logic [sdoi_pkg::ERR_N-1:0] err_detect
);
  import sdoi_pkg::*;
  int ref_pulses = 0;
  initial err_detect = '0;
  // Counts cycles with the strobe high, so a stuck strobe shows as many
  always @(posedge ref_clk)
    if (!rst && drive.feedback_set_reference === 1'b1)
      ref_pulses <= ref_pulses + 1;
  // Short detector burst; the flag must outlive it
  task automatic raise(input int k);
    err_detect[k] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    err_detect[k] <= 1'b0;
  endtask : raise
endmodule : sdoi_drive_model

// File: verification/testbench.sv
// Self-checking bench of the axis 1 output image over AHB-Lite.
// Assumes zero wait states are not relied on: every wait in the bus task polls hready.
`timescale 1ns/1ns
module testbench;
  import sdoi_pkg::*;
  localparam int CYC = 8;
  localparam int SETTLE = CYC + 4;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0000_0000;
  wire logic hready;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [ERR_N-1:0] err_detect;
  sdoi_drive_t drive;
  logic [ERR_N-1:0] err_active;
  logic [31:0] rd;
  logic [31:0] mexp [8] = '{32'h0001_0007, 32'h0000_0001, 32'h0000_FFFF, 32'h0000_0000,
    32'h0007_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000};
  int ack_w [3] = '{0, 0, 4};
  int ack_b [3] = '{1, 16, 17};
  int n_fail = 0;
  int checks_done = 0;
  assign hready = hreadyout;
  always #5 ref_clk = ~ref_clk;
  sdoi_top #(.CYCLE_CLKS(CYC), .HIST_DEPTH(16)) dut_u (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .err_detect(err_detect), .drive(drive),
    .err_active(err_active));
  sdoi_drive_model drv_u (.ref_clk(ref_clk), .rst(rst), .drive(drive), .err_detect(err_detect));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : idle
  // One single word transfer, entered right after a rising edge
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge ref_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge ref_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdc(input logic [31:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp, what);
  endtask : rdc
  initial
  begin
    idle(5000);
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    idle(8);
    rst <= 1'b0;
    idle(1);
    chk(32'({hresp, hreadyout}), 32'h0000_0001, "bus response");
    chk(32'(drive), 32'h0000_0000, "drive after reset");
    rdc(32'(OFS_STATUS), 32'h0000_0000, "status after reset");
    $display("test reset done");
    for (int w = 0; w < 8; w++)
    begin
      bus(1'b1, 32'(4 * w), 32'hFFFF_FFFF);
      rdc(32'(4 * w), mexp[w], "image mask");
      idle(SETTLE);
    end
    chk(32'(drive), 32'h0000_001E, "drive levels on");
    chk(32'(drv_u.ref_pulses), 32'h0000_0001, "reference strobe");
    rdc(32'(OFS_STATUS), 32'h0000_0F00, "status levels on");
    $display("test image write done");
    for (int w = 0; w < 8; w++)
      bus(1'b1, 32'(4 * w), 32'h0000_0000);
    idle(SETTLE + DIAG_BITS);
    chk(32'(drive), 32'h0000_0000, "drive levels off");
    rdc(32'(OFS_STATUS), 32'h0010_0000, "history count");
    for (int k = 0; k < 16; k++)
    begin
      bus(1'b1, 32'(OFS_HIST_IDX), 32'(k));
      idle(2);
      rdc(32'(OFS_HIST_DATA), 32'(16'hD300 + k), "history code");
    end
    $display("test diagnostic history done");
    for (int k = 0; k < ERR_N; k++)
    begin
      drv_u.raise(k);
      idle(2);
      chk(32'(err_active), 32'(1 << k), "error held");
      rdc(32'(OFS_STATUS), 32'h0010_0000 | 32'(1 << k), "status error flag");
      bus(1'b1, 32'(4 * ack_w[k]), 32'h0000_0001 << ack_b[k]);
      idle(SETTLE);
      chk(32'(err_active), 32'h0000_0000, "error cleared");
      bus(1'b1, 32'(4 * ack_w[k]), 32'h0000_0000);
      idle(SETTLE);
    end
    $display("test acknowledge done");
    bus(1'b1, 32'h0000_0104, 32'hFFFF_FFFF);
    rdc(32'h0000_0004, 32'h0000_0000, "unmapped write alias");
    rdc(32'h0000_002C, 32'h0000_0000, "unmapped read");
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule : testbench
